// file: gate_predriver_cfg.svh
`ifndef GATE_PREDRIVER_CFG_SVH
`define GATE_PREDRIVER_CFG_SVH
// How it works
// RQ1 - Timer code picks 30 to 960 us
// RQ2 - Drain over threshold too long switches off
// RQ3 - Detected at once, declared after timer
// RQ4 - Per-channel retry bit returns output after inhibit
// RQ5 - Retry off time is hundred fault times
// RQ6 - Retry only if not commanded off meanwhile
// RQ7 - Shutdown mode latches off until fresh on
// RQ8 - PWM short: off interval, resume next cycle
// RQ9 - Host keeps timer below minimum on-time
// RQ10 - New frequency and duty apply at rising edge
// RQ11 - PWM switched by parallel or serial bit
// RQ12 - On/off changes wait for period start
// RQ13 - Duty one percent per count, capped
// RQ14 - Frequency code gives 10 Hz to 1.28 kHz
// RQ15 - Short pulses escape fault timer detection
// RQ16 - Gate output truth table in general mode
// RQ17 - Threshold code picks 0.5 to 3.0 V
// RQ18 - Serial on bits drive general outputs only
// RQ19 - Retry interval counted on calibrated timebase
// RQ20 - Short flag sticks until status read

`define CHANNELS             4
`define CLOCK_HZ             100000000
`define US_PER_S             1000000
`define TICK_US_CYCLES       (`CLOCK_HZ / `US_PER_S)
`define FAULT_TIMER_BASE_US  30
`define FAULT_TIMER_RESET    3'h3
`define FAULT_TIMER_MAX_CODE 3'h5
`define THRESHOLD_RESET      3'h3
`define THRESHOLD_MAX_CODE   3'h5
`define RETRY_MULT           100
`define PWM_BASE_HZ          10
`define PWM_STEPS            100
`define PWM_BASE_STEP_CYCLES (`CLOCK_HZ / (`PWM_BASE_HZ * `PWM_STEPS))
`define PWM_LAST_STEP        7'h63
`define DUTY_FULL            7'h64
`define DUTY_LSB             0
`define DUTY_MSB             6
`define FREQ_LSB             7
`define FREQ_MSB             9
`define FREQ_RESET           3'h0
`define DUTY_RESET           7'h00
`endif

// file: gate_predriver_pkg.sv
`include "gate_predriver_cfg.svh"
package gate_predriver_pkg;
  typedef enum logic [1:0] {
    CH_NORMAL     = 2'b00,
    CH_RETRY_WAIT = 2'b01,
    CH_LATCHED    = 2'b10
  } fault_state_type;

  typedef struct packed {
    logic [2:0] freq;
    logic [6:0] duty;
  } pwm_setting_type;

  typedef struct packed {
    logic       write;
    logic [1:0] channel;
    logic [9:0] data;
  } pwm_command_type;

  typedef struct packed {
    fault_state_type fstate;
    logic [9:0]      fault_cnt;
    logic [16:0]     off_cnt;
    logic            cmd_prev;
    logic            cmd_off_seen;
    logic            short_flag;
    logic            pwm_hold;
    logic            run;
    pwm_setting_type pending;
    pwm_setting_type active;
    logic [16:0]     step_cnt;
    logic [6:0]      pct;
    logic            out;
  } channel_type;

  typedef struct packed {
    logic [`CHANNELS-1:0]  gin_meta;
    logic [`CHANNELS-1:0]  gin_sync;
    logic [`CHANNELS-1:0]  fb_meta;
    logic [`CHANNELS-1:0]  fb_sync;
    logic [6:0]            us_cnt;
    logic                  us_tick;
    logic [2:0]            timer_code;
    logic [2:0]            threshold_code;
    channel_type [`CHANNELS-1:0] ch;
  } ctrl_state_type;
endpackage

// file: gate_predriver_pwm_fault_ctrl.sv
`timescale 1ns/100ps
`include "gate_predriver_cfg.svh"
module gate_predriver_pwm_fault_ctrl #(
  parameter int PWM_STEP_CYCLES = `PWM_BASE_STEP_CYCLES
) (
  input  wire logic                            clock,
  input  wire logic                            rst,
  input  wire logic [`CHANNELS-1:0]            gate_parallel_input,
  input  wire logic [`CHANNELS-1:0]            drain_feedback_input,
  input  wire logic [`CHANNELS-1:0]            spi_gate_on,
  input  wire logic [`CHANNELS-1:0]            pwm_channel_enable,
  input  wire logic [`CHANNELS-1:0]            ignition_or_general_select,
  input  wire logic [`CHANNELS-1:0]            retry_shutdown,
  input  wire logic                            fault_timer_write,
  input  wire logic [2:0]                      short_fault_timer_field,
  input  wire logic                            threshold_write,
  input  wire logic [2:0]                      drain_threshold_field,
  input  wire gate_predriver_pkg::pwm_command_type pwm_frequency_duty_command,
  input  wire logic                            fault_status_read,
  output logic [`CHANNELS-1:0]                 gate_drive_output,
  output logic [`CHANNELS-1:0]                 short_fault_flag,
  output logic [2:0]                           drain_threshold_select,
  output logic [2:0]                           fault_timer_select
);
  import gate_predriver_pkg::*;

  ctrl_state_type       s;
  ctrl_state_type       next_s;
  logic [`CHANNELS-1:0] cmd;
  logic [`CHANNELS-1:0] over;
  logic [`CHANNELS-1:0] declare;
  logic [`CHANNELS-1:0] period_start;
  logic [`CHANNELS-1:0] wave;
  logic [`CHANNELS-1:0] base;
  logic [9:0]           limit_us;
  logic [16:0]          off_len;
  logic [16:0]          step_len [`CHANNELS];
  logic [6:0]           duty_eff [`CHANNELS];

  always_comb begin
    next_s = s;
    cmd = '0;
    over = '0;
    declare = '0;
    period_start = '0;
    wave = '0;
    base = '0;
    for (int i = 0; i < `CHANNELS; i++) begin
      step_len[i] = '0;
      duty_eff[i] = '0;
    end

    next_s.gin_meta = gate_parallel_input;
    next_s.gin_sync = s.gin_meta;
    next_s.fb_meta  = drain_feedback_input;
    next_s.fb_sync  = s.fb_meta;

    // The microsecond tick is the calibrated timebase for every fault count.
    next_s.us_tick = 1'b0;
    if (s.us_cnt >= 7'(`TICK_US_CYCLES - 1)) begin // [RQ19]
      next_s.us_cnt  = '0;
      next_s.us_tick = 1'b1;
    end else begin
      next_s.us_cnt = s.us_cnt + 7'h01;
    end

    // Codes above the top entry keep the old setting.
    if (fault_timer_write && short_fault_timer_field <= `FAULT_TIMER_MAX_CODE) begin // [RQ1]
      next_s.timer_code = short_fault_timer_field;
    end
    if (threshold_write && drain_threshold_field <= `THRESHOLD_MAX_CODE) begin // [RQ17]
      next_s.threshold_code = drain_threshold_field;
    end

    limit_us = 10'(`FAULT_TIMER_BASE_US) << s.timer_code; // [RQ1]
    off_len  = 17'(`RETRY_MULT) * 17'(limit_us); // [RQ5]

    for (int i = 0; i < `CHANNELS; i++) begin
      // Ignition channels ignore the serial bit and run off the pin alone.
      cmd[i] = (spi_gate_on[i] & ignition_or_general_select[i]) | s.gin_sync[i]; // [RQ18]

      if (pwm_frequency_duty_command.write && pwm_frequency_duty_command.channel == 2'(i)) begin
        next_s.ch[i].pending.duty = pwm_frequency_duty_command.data[`DUTY_MSB:`DUTY_LSB];
        next_s.ch[i].pending.freq = pwm_frequency_duty_command.data[`FREQ_MSB:`FREQ_LSB];
      end

      // Each doubling of frequency halves the length of one percent step.
      step_len[i] = 17'(PWM_STEP_CYCLES) >> s.ch[i].active.freq; // [RQ14]
      if (s.ch[i].step_cnt >= step_len[i] - 17'h0_0001) begin
        next_s.ch[i].step_cnt = '0;
        if (s.ch[i].pct >= `PWM_LAST_STEP) begin
          next_s.ch[i].pct = '0;
          period_start[i]  = 1'b1;
        end else begin
          next_s.ch[i].pct = s.ch[i].pct + 7'h01;
        end
      end else begin
        next_s.ch[i].step_cnt = s.ch[i].step_cnt + 17'h0_0001;
      end

      if (period_start[i]) begin
        next_s.ch[i].active = s.ch[i].pending; // [RQ10]
        next_s.ch[i].run    = cmd[i]; // [RQ11] [RQ12]
        if (s.ch[i].fstate == CH_NORMAL) begin
          next_s.ch[i].pwm_hold = 1'b0; // [RQ8]
        end
      end

      duty_eff[i] = (next_s.ch[i].active.duty > `DUTY_FULL) ? `DUTY_FULL : next_s.ch[i].active.duty; // [RQ13]
      wave[i] = next_s.ch[i].pct < duty_eff[i];

      // Short detection only looks at a general channel that is driven on.
      over[i] = s.fb_sync[i] & s.ch[i].out & ignition_or_general_select[i]; // [RQ3]
      if (!over[i]) begin
        next_s.ch[i].fault_cnt = '0;
      end else if (s.us_tick && s.ch[i].fault_cnt <= limit_us) begin
        next_s.ch[i].fault_cnt = s.ch[i].fault_cnt + 10'h001;
      end
      // Declared only once the excess has outlasted the timer; short pulses never get there.
      declare[i] = over[i] && (s.ch[i].fault_cnt > limit_us); // [RQ3] [RQ15]

      next_s.ch[i].cmd_prev = cmd[i];

      case (s.ch[i].fstate)
        CH_NORMAL: begin
          if (declare[i]) begin
            next_s.ch[i].fault_cnt    = '0;
            next_s.ch[i].off_cnt      = off_len; // [RQ5] [RQ19]
            next_s.ch[i].cmd_off_seen = 1'b0;
            next_s.ch[i].pwm_hold     = pwm_channel_enable[i]; // [RQ8]
            if (pwm_channel_enable[i] || retry_shutdown[i]) begin
              next_s.ch[i].fstate = CH_RETRY_WAIT; // [RQ4] [RQ8]
            end else begin
              next_s.ch[i].fstate = CH_LATCHED; // [RQ7]
            end
          end
        end
        CH_RETRY_WAIT: begin
          if (!cmd[i]) begin
            next_s.ch[i].cmd_off_seen = 1'b1; // [RQ6]
          end
          if (s.us_tick) begin
            if (s.ch[i].off_cnt <= 17'h0_0001) begin
              // An off command during the wait means only a fresh on may restart.
              next_s.ch[i].off_cnt = '0;
              next_s.ch[i].fstate  = (s.ch[i].cmd_off_seen || !cmd[i]) ? CH_LATCHED : CH_NORMAL; // [RQ6]
            end else begin
              next_s.ch[i].off_cnt = s.ch[i].off_cnt - 17'h0_0001; // [RQ19]
            end
          end
        end
        CH_LATCHED: begin
          if (cmd[i] && !s.ch[i].cmd_prev) begin
            next_s.ch[i].fstate = CH_NORMAL; // [RQ7]
          end
        end
        default: begin
          next_s.ch[i].fstate = CH_NORMAL;
        end
      endcase

      // A short arriving in the read cycle keeps its flag.
      next_s.ch[i].short_flag = (s.ch[i].short_flag & ~fault_status_read) | declare[i]; // [RQ20]

      if (!ignition_or_general_select[i]) begin
        base[i] = s.gin_sync[i];
      end else if (pwm_channel_enable[i]) begin
        base[i] = next_s.ch[i].run & wave[i] & ~next_s.ch[i].pwm_hold; // [RQ16]
      end else begin
        base[i] = cmd[i]; // [RQ16]
      end
      next_s.ch[i].out = base[i] & (~ignition_or_general_select[i] | (next_s.ch[i].fstate == CH_NORMAL)); // [RQ2]
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      s <= '0;
      s.timer_code <= `FAULT_TIMER_RESET;
      s.threshold_code <= `THRESHOLD_RESET;
      for (int i = 0; i < `CHANNELS; i++) begin
        s.ch[i].fstate <= CH_NORMAL;
        s.ch[i].pending <= {`FREQ_RESET, `DUTY_RESET};
        s.ch[i].active <= {`FREQ_RESET, `DUTY_RESET};
      end
    end else begin
      s <= next_s;
    end
  end

  always_comb begin
    for (int i = 0; i < `CHANNELS; i++) begin
      gate_drive_output[i] = s.ch[i].out;
      short_fault_flag[i]  = s.ch[i].short_flag;
    end
    drain_threshold_select = s.threshold_code;
    fault_timer_select     = s.timer_code;
  end

  default clocking @(posedge clock); endclocking
  default disable iff (rst);

  AST_TIMER_NO_CHANGE: assert property ( // [RQ1]
    fault_timer_write && short_fault_timer_field > `FAULT_TIMER_MAX_CODE |=> $stable(fault_timer_select))
    else $error("Reserved timer code changed the setting");

  AST_TIMER_TAKEN: assert property ( // [RQ1]
    fault_timer_write && short_fault_timer_field <= `FAULT_TIMER_MAX_CODE
      |=> fault_timer_select == $past(short_fault_timer_field))
    else $error("Valid timer code was not taken");

  AST_THRESHOLD_NO_CHANGE: assert property ( // [RQ17]
    threshold_write && drain_threshold_field > `THRESHOLD_MAX_CODE |=> $stable(drain_threshold_select))
    else $error("Reserved threshold code changed the setting");

  for (genvar g = 0; g < `CHANNELS; g++) begin : chk
    AST_DECLARE_OFF: assert property ( // [RQ2]
      declare[g] |=> !gate_drive_output[g])
      else $error("Output stayed on after a declared short");

    AST_DETECT_NOT_DECLARE: assert property ( // [RQ3]
      $rose(over[g]) && s.ch[g].fault_cnt == 10'h000 |-> !declare[g] [*8])
      else $error("Short declared before the timer ran");

    AST_RETRY_LOAD: assert property ( // [RQ5]
      declare[g] && (retry_shutdown[g] || pwm_channel_enable[g])
        |=> s.ch[g].fstate == CH_RETRY_WAIT && s.ch[g].off_cnt == 17'(`RETRY_MULT) * 17'($past(limit_us)))
      else $error("Retry interval not loaded with hundred fault times");

    AST_LATCH_OFF: assert property ( // [RQ7]
      declare[g] && !retry_shutdown[g] && !pwm_channel_enable[g] |=> s.ch[g].fstate == CH_LATCHED)
      else $error("Shutdown mode did not latch off");

    AST_RETRY_OFF_SEEN: assert property ( // [RQ6]
      s.ch[g].fstate == CH_RETRY_WAIT && s.ch[g].cmd_off_seen |=> s.ch[g].fstate != CH_NORMAL)
      else $error("Retry turned on after an off command");

    AST_APPLY_AT_EDGE: assert property ( // [RQ10]
      !period_start[g] |=> $stable(s.ch[g].active))
      else $error("PWM setting applied away from the period start");

    AST_DIRECT_OFF: assert property ( // [RQ16]
      ignition_or_general_select[g] && !pwm_channel_enable[g] && !cmd[g] |=> !gate_drive_output[g])
      else $error("Direct mode output on without command");

    AST_FLAG_SET: assert property ( // [RQ20]
      declare[g] |=> short_fault_flag[g])
      else $error("Short flag not set on declared short");
  end
endmodule

// file: mosfet_load_model.sv
`timescale 1ns/100ps
module mosfet_load_model (
  input  wire logic [3:0] gate,
  input  wire logic [3:0] shorted,
  output logic [3:0]      drain
);
  // The load pulls the drain to supply while off, so only a short keeps it high once the gate is on.
  assign drain = shorted | ~gate;
endmodule

// file: gate_predriver_pwm_fault_ctrl_tb.sv
`timescale 1ns/100ps
`define CHECK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; $display("BAD t=%0t got=%h exp=%h", $time, a, b); end end
module gate_predriver_pwm_fault_ctrl_tb;
  import gate_predriver_pkg::*;
  typedef struct packed {logic [1:0] op; logic [2:0] a; logic [2:0] exp;} row_type;
  logic            clock = 0;
  logic            rst = 1;
  logic [3:0]      pin = 0;
  logic [3:0]      drain;
  logic [3:0]      spi = 0;
  logic [3:0]      pwm_en = 0;
  logic [3:0]      gen = 0;
  logic [3:0]      retry = 0;
  logic [3:0]      shorted = 0;
  logic            tw = 0;
  logic            thw = 0;
  logic [2:0]      field = 0;
  logic            rd = 0;
  pwm_command_type pwm_cmd = '0;
  logic [3:0]      gate;
  logic [3:0]      flag;
  logic [2:0]      thr_sel;
  logic [2:0]      tim_sel;
  int              bad_count = 0;
  int              compares = 0;
  int              cycles = 0;
  int              n;
  row_type rows [14] = '{'{2'h0, 3'h7, 3'h3}, '{2'h0, 3'h5, 3'h5}, '{2'h0, 3'h6, 3'h5}, '{2'h0, 3'h0, 3'h0},
    '{2'h1, 3'h6, 3'h3}, '{2'h1, 3'h1, 3'h1}, '{2'h1, 3'h7, 3'h1}, '{2'h1, 3'h5, 3'h5},
    '{2'h2, 3'h4, 3'h0}, '{2'h2, 3'h5, 3'h1}, '{2'h2, 3'h6, 3'h1}, '{2'h2, 3'h2, 3'h0},
    '{2'h2, 3'h1, 3'h1}, '{2'h2, 3'h4, 3'h0}};

  gate_predriver_pwm_fault_ctrl #(.PWM_STEP_CYCLES(128)) uut (
    .clock(clock), .rst(rst), .gate_parallel_input(pin), .drain_feedback_input(drain),
    .spi_gate_on(spi), .pwm_channel_enable(pwm_en), .ignition_or_general_select(gen),
    .retry_shutdown(retry), .fault_timer_write(tw), .short_fault_timer_field(field),
    .threshold_write(thw), .drain_threshold_field(field), .pwm_frequency_duty_command(pwm_cmd),
    .fault_status_read(rd), .gate_drive_output(gate), .short_fault_flag(flag),
    .drain_threshold_select(thr_sel), .fault_timer_select(tim_sel));

  mosfet_load_model load (.gate(gate), .shorted(shorted), .drain(drain));

  always #5 clock = ~clock;

  always @(posedge clock) begin
    cycles++;
    if (cycles == 25000) begin
      bad_count++;
      stop_test;
    end
  end

  task automatic stop_test;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic pwm_set(input logic [1:0] ch, input logic [2:0] f, input logic [6:0] d);
    @(negedge clock);
    pwm_cmd = '{1'b1, ch, {f, d}};
    @(negedge clock);
    pwm_cmd.write = 1'b0;
  endtask

  // Counts high cycles of channel 1 over a whole number of PWM periods.
  task automatic count_high(input int len, output int h);
    h = 0;
    repeat (len) begin
      @(negedge clock);
      if (gate[1] === 1'b1) h++;
    end
  endtask

  initial begin
    repeat (2) @(negedge clock);
    `CHECK({gate, flag, thr_sel, tim_sel}, 14'h001b)
    rst = 0;
    // Loaded early: it only takes over at the end of the long first period at the reset frequency.
    pwm_set(2'h1, 3'h7, 7'h19);
    foreach (rows[i]) begin
      @(negedge clock);
      field = rows[i].a;
      tw = (rows[i].op == 2'h0);
      thw = (rows[i].op == 2'h1);
      if (rows[i].op == 2'h2) {gen[0], spi[0], pin[0]} = rows[i].a;
      @(negedge clock);
      tw = 0;
      thw = 0;
      repeat (6) @(negedge clock);
      `CHECK(rows[i].op == 2'h0 ? tim_sel : rows[i].op == 2'h1 ? thr_sel : {2'h0, gate[0]}, rows[i].exp)
    end
    spi[0] = 1;
    // Channel 2 runs in retry mode beside the latching channel 0 and sees the same short.
    {gen[2], spi[2], retry[2]} = 3'h7;
    repeat (10) @(negedge clock);
    `CHECK(gate[0], 1'b1)
    shorted = 4'h5;
    n = 0;
    while (gate[0] === 1'b1 && n < 4000) begin
      @(negedge clock);
      n++;
    end
    `CHECK(n >= 3000 && n <= 3300, 1'b1)
    `CHECK(flag[0], 1'b1)
    repeat (500) @(negedge clock);
    `CHECK({gate[0], flag[0]}, 2'h1)
    `CHECK({gate[2], flag[2]}, 2'h1)
    rd = 1;
    @(negedge clock);
    rd = 0;
    shorted = 4'h0;
    @(negedge clock);
    `CHECK(flag[0], 1'b0)
    `CHECK(gate[0], 1'b0)
    spi[0] = 0;
    repeat (3) @(negedge clock);
    spi[0] = 1;
    repeat (6) @(negedge clock);
    `CHECK(gate[0], 1'b1)
    // The fault timer stays at its shortest code, still longer than the 25% and 50% duty on-times below; channel 1 is not shorted.
    {gen[1], pwm_en[1], spi[1]} = 3'h7;
    while (cycles < 13000) @(negedge clock);
    count_high(200, n);
    `CHECK(n, 50)
    pwm_set(2'h1, 3'h7, 7'h7f);
    repeat (450) @(negedge clock);
    count_high(200, n);
    `CHECK(n, 200)
    pwm_set(2'h1, 3'h6, 7'h32);
    repeat (900) @(negedge clock);
    count_high(400, n);
    `CHECK(n, 200)
    n = 0;
    while (gate[1] === 1'b1 && n < 1000) begin
      @(negedge clock);
      n++;
    end
    while (gate[1] === 1'b0 && n < 2000) begin
      @(negedge clock);
      n++;
    end
    spi[1] = 0;
    repeat (10) @(negedge clock);
    `CHECK(gate[1], 1'b1)
    repeat (800) @(negedge clock);
    `CHECK(gate[1], 1'b0)
    // The retry interval is far longer than the run, so channel 2 must still be held off.
    `CHECK(gate[2], 1'b0)
    stop_test;
  end
endmodule
